// [terf_pkg.sv]
//==========================================================
//==========================================================
package terf_pkg;

  //==========================================================
  // Register offsets (byte addresses, one word each)
  //==========================================================
  localparam logic [7:0] ADDR_VIEW_CTL    = 8'h00; // Instruction trace view control
  localparam logic [7:0] ADDR_ID_SIX      = 8'h04; // Feature identification six
  localparam logic [7:0] ADDR_STATUS      = 8'h08; // Last decision status
  localparam logic [7:0] ADDR_CNT_TRACED  = 8'h0C; // Traced instruction count
  localparam logic [7:0] ADDR_CNT_SUPPR   = 8'h10; // Suppressed instruction count

  //==========================================================
  // View control field positions
  //==========================================================
  localparam int unsigned BIT_EL3_SUPPRESS = 19; // el3_trace_suppress
  localparam int unsigned BIT_NS_EL0       = 20; // nonsecure_el0_trace_filter
  localparam int unsigned BIT_NS_EL1       = 21; // nonsecure_el1_trace_filter
  localparam int unsigned BIT_NS_EL2       = 22; // nonsecure_el2_trace_filter
  localparam int unsigned BIT_RL_EL0       = 24; // realm_el0_trace_filter
  localparam int unsigned BIT_RL_EL1       = 25; // realm_el1_trace_filter
  localparam int unsigned BIT_RL_EL2       = 26; // realm_el2_trace_filter

  // Only the filter bits above are storable; the rest read as zero
  localparam logic [31:0] VIEW_CTL_WMASK = 32'h0778_0000;
  // Any reset value is allowed; zero keeps the filter state defined
  localparam logic [31:0] VIEW_CTL_RESET = 32'h0000_0000;

  //==========================================================
  // Identification six: Realm EL0, EL1, EL2 implemented
  //==========================================================
  localparam int unsigned ID_RL_EL0_BIT = 0;
  localparam int unsigned ID_RL_EL1_BIT = 1;
  localparam int unsigned ID_RL_EL2_BIT = 2;
  localparam logic [31:0] ID_SIX_VALUE  = 32'h0000_0007;

  //==========================================================
  // Status field positions and counter reset
  //==========================================================
  localparam int unsigned STS_TRACED_BIT = 0; // Last retired was traced
  localparam int unsigned STS_SEEN_BIT   = 1; // Any instruction retired
  localparam int unsigned STS_EL_LSB     = 2; // Last exception level
  localparam int unsigned STS_SEC_LSB    = 4; // Last security state
  localparam logic [31:0] CNT_RESET      = 32'h0000_0000;

  //==========================================================
  // Exception level and security state encodings
  //==========================================================
  typedef enum logic [1:0] {
    TERF_EL0,
    TERF_EL1,
    TERF_EL2,
    TERF_EL3
  } terf_el_t;

  // Encoded as {NSE, NS}
  typedef enum logic [1:0] {
    TERF_SECURE,
    TERF_NONSECURE,
    TERF_ROOT,
    TERF_REALM
  } terf_sec_t;

endpackage

// [terf_ctl_if.sv]
`timescale 1ns/100ps
//==========================================================
// Carries control and retire state to the decision logic
//==========================================================
interface terf_ctl_if;
  logic [31:0]        view_ctl;     // Stored view control word
  logic               retire_valid; // Instruction retires this cycle
  terf_pkg::terf_el_t el;           // Level it executed at
  terf_pkg::terf_sec_t sec;         // Security state it executed in
  logic               gen;          // Trace is generated for it

  modport top (
    output view_ctl,
    output retire_valid,
    output el,
    output sec,
    input  gen
  );

  modport dec (
    input  view_ctl,
    input  retire_valid,
    input  el,
    input  sec,
    output gen
  );
endinterface

// [terf_decide.sv]
`timescale 1ns/100ps
//==========================================================
// Per-instruction trace decision, purely combinational
//==========================================================
module terf_decide (
  terf_ctl_if.dec ctl
);

  logic rl_el0_match; // Realm EL0 bit equals Non-secure EL0 bit
  logic rl_el1_match; // Realm EL1 bit equals Non-secure EL1 bit
  logic rl_el2_match; // Realm EL2 bit equals Non-secure EL2 bit

  assign rl_el0_match = ctl.view_ctl[terf_pkg::BIT_RL_EL0] == ctl.view_ctl[terf_pkg::BIT_NS_EL0];
  assign rl_el1_match = ctl.view_ctl[terf_pkg::BIT_RL_EL1] == ctl.view_ctl[terf_pkg::BIT_NS_EL1];
  assign rl_el2_match = ctl.view_ctl[terf_pkg::BIT_RL_EL2] == ctl.view_ctl[terf_pkg::BIT_NS_EL2];

  //==========================================================
  // Select the control that matches the state in effect
  //==========================================================
  always_comb begin
    ctl.gen = 1'b0;
    if (ctl.retire_valid) begin
      if (ctl.el == terf_pkg::TERF_EL3) begin
        // EL3 has one bit whatever the security state
        ctl.gen = ~ctl.view_ctl[terf_pkg::BIT_EL3_SUPPRESS];
      end else begin
        unique case (ctl.sec)
          terf_pkg::TERF_REALM: begin
            // Realm levels trace only when paired bits agree
            unique case (ctl.el)
              terf_pkg::TERF_EL0: ctl.gen = rl_el0_match;
              terf_pkg::TERF_EL1: ctl.gen = rl_el1_match;
              default:            ctl.gen = rl_el2_match;
            endcase
          end
          terf_pkg::TERF_NONSECURE: begin
            // Non-secure bits set mean no trace at that level
            unique case (ctl.el)
              terf_pkg::TERF_EL0: ctl.gen = ~ctl.view_ctl[terf_pkg::BIT_NS_EL0];
              terf_pkg::TERF_EL1: ctl.gen = ~ctl.view_ctl[terf_pkg::BIT_NS_EL1];
              default:            ctl.gen = ~ctl.view_ctl[terf_pkg::BIT_NS_EL2];
            endcase
          end
          // Secure below EL3 and stray Root codes are not filtered here
          default: ctl.gen = 1'b1;
        endcase
      end
    end
  end

endmodule

// [terf_filter.sv]
`timescale 1ns/100ps
//==========================================================
// Trace exception-level and Realm filter, top level
//==========================================================
module terf_filter (
  input  wire logic        clk_i,          // 250 MHz trace clock
  input  wire logic        rst_i,          // Trace unit reset, async high
  // Register port
  input  wire logic [7:0]  addr_i,         // Byte address
  input  wire logic [31:0] wr_data_i,      // Write data
  input  wire logic        wr_en_i,        // Write strobe
  input  wire logic        rd_en_i,        // Read strobe
  output logic      [31:0] rd_data_o,      // Read data, one cycle later
  // Core retire report
  input  wire logic        retire_valid_i, // Instruction retires
  input  wire logic [1:0]  retire_el_i,    // Exception level at execution
  input  wire logic [1:0]  retire_sec_i,   // {NSE, NS} at execution
  input  wire logic [31:0] retire_pc_i,    // Instruction address
  // Filtered trace out
  output logic             trace_valid_o,  // Traced instruction pulse
  output logic      [1:0]  trace_el_o,     // Its exception level
  output logic      [1:0]  trace_sec_o,    // Its security state
  output logic      [31:0] trace_pc_o,     // Its address
  output logic             suppress_o      // Filtered-out pulse
);

  //==========================================================
  // Declarations
  //==========================================================
  terf_ctl_if ctl_if ();                  // Link to decision logic

  logic [31:0] view_ctl_q;                // Stored view control
  logic [31:0] view_ctl_d;
  logic [31:0] rd_data_q;                 // Registered read data
  logic [31:0] rd_data_d;
  logic [31:0] cnt_traced_q;              // Traced count
  logic [31:0] cnt_traced_d;
  logic [31:0] cnt_suppr_q;               // Suppressed count
  logic [31:0] cnt_suppr_d;
  logic [31:0] status_q;                  // Last decision status
  logic [31:0] status_d;
  logic        trace_valid_q;             // Output stage
  logic        trace_valid_d;
  logic [1:0]  trace_el_q;
  logic [1:0]  trace_el_d;
  logic [1:0]  trace_sec_q;
  logic [1:0]  trace_sec_d;
  logic [31:0] trace_pc_q;
  logic [31:0] trace_pc_d;
  logic        suppress_q;
  logic        suppress_d;

  logic        wr_view_ctl;               // Write hits view control
  logic        wr_cnt_traced;             // Write clears traced count
  logic        wr_cnt_suppr;              // Write clears suppressed count
  logic        gen;                       // Decision for this retire
  logic        drop;                      // Retire filtered out

  //==========================================================
  // Decision logic hookup
  //==========================================================
  // The decision sees the state the instruction ran in, not
  // any later state, so no extra staging sits in front of it
  assign ctl_if.view_ctl     = view_ctl_q;
  assign ctl_if.retire_valid = retire_valid_i;
  assign ctl_if.el           = terf_pkg::terf_el_t'(retire_el_i);
  assign ctl_if.sec          = terf_pkg::terf_sec_t'(retire_sec_i);
  assign gen                 = ctl_if.gen;
  assign drop                = retire_valid_i & ~gen;

  terf_decide u_decide (
    .ctl (ctl_if.dec)
  );

  //==========================================================
  // Write decode
  //==========================================================
  assign wr_view_ctl   = wr_en_i & (addr_i == terf_pkg::ADDR_VIEW_CTL);
  assign wr_cnt_traced = wr_en_i & (addr_i == terf_pkg::ADDR_CNT_TRACED);
  assign wr_cnt_suppr  = wr_en_i & (addr_i == terf_pkg::ADDR_CNT_SUPPR);

  //==========================================================
  // View control register
  //==========================================================
  // Only filter bits are kept; other bits are dropped on write
  always_comb begin
    view_ctl_d = view_ctl_q;
    if (wr_view_ctl) begin
      view_ctl_d = wr_data_i & terf_pkg::VIEW_CTL_WMASK;
    end
  end

  // Reset value is a free choice; software must still program it
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      view_ctl_q <= terf_pkg::VIEW_CTL_RESET;
    end else begin
      view_ctl_q <= view_ctl_d;
    end
  end

  //==========================================================
  // Instruction counters
  //==========================================================
  // A write clears a counter, but a retire in the same cycle
  // still counts, so the count restarts at one, not zero
  always_comb begin
    cnt_traced_d = cnt_traced_q;
    cnt_suppr_d  = cnt_suppr_q;
    if (wr_cnt_traced) begin
      cnt_traced_d = terf_pkg::CNT_RESET;
    end
    if (wr_cnt_suppr) begin
      cnt_suppr_d = terf_pkg::CNT_RESET;
    end
    if (gen) begin
      cnt_traced_d = cnt_traced_d + 32'h0000_0001;
    end
    if (drop) begin
      cnt_suppr_d = cnt_suppr_d + 32'h0000_0001;
    end
  end

  // Counters wrap silently at full scale
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      cnt_traced_q <= terf_pkg::CNT_RESET;
      cnt_suppr_q  <= terf_pkg::CNT_RESET;
    end else begin
      cnt_traced_q <= cnt_traced_d;
      cnt_suppr_q  <= cnt_suppr_d;
    end
  end

  //==========================================================
  // Last decision status
  //==========================================================
  // Holds the most recent retire until the next one arrives
  always_comb begin
    status_d = status_q;
    if (retire_valid_i) begin
      status_d                                    = 32'h0000_0000;
      status_d[terf_pkg::STS_TRACED_BIT]          = gen;
      status_d[terf_pkg::STS_SEEN_BIT]            = 1'b1;
      status_d[terf_pkg::STS_EL_LSB +: 2]         = retire_el_i;
      status_d[terf_pkg::STS_SEC_LSB +: 2]        = retire_sec_i;
    end
  end

  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      status_q <= 32'h0000_0000;
    end else begin
      status_q <= status_d;
    end
  end

  //==========================================================
  // Filtered trace output stage
  //==========================================================
  // One stage of latency keeps every output on a flip-flop;
  // the address and state travel with the valid pulse
  always_comb begin
    trace_valid_d = gen;
    suppress_d    = drop;
    trace_el_d    = trace_el_q;
    trace_sec_d   = trace_sec_q;
    trace_pc_d    = trace_pc_q;
    if (gen) begin
      // Fields only move on a traced instruction
      trace_el_d  = retire_el_i;
      trace_sec_d = retire_sec_i;
      trace_pc_d  = retire_pc_i;
    end
  end

  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      trace_valid_q <= 1'b0;
      suppress_q    <= 1'b0;
      trace_el_q    <= 2'h0;
      trace_sec_q   <= 2'h0;
      trace_pc_q    <= 32'h0000_0000;
    end else begin
      trace_valid_q <= trace_valid_d;
      suppress_q    <= suppress_d;
      trace_el_q    <= trace_el_d;
      trace_sec_q   <= trace_sec_d;
      trace_pc_q    <= trace_pc_d;
    end
  end

  //==========================================================
  // Read mux
  //==========================================================
  // Data stand for exactly one cycle after the strobe, then
  // drop to zero so a stale word is never mistaken for new
  always_comb begin
    rd_data_d = 32'h0000_0000;
    if (rd_en_i) begin
      unique case (addr_i)
        terf_pkg::ADDR_VIEW_CTL:   rd_data_d = view_ctl_q;
        terf_pkg::ADDR_ID_SIX:     rd_data_d = terf_pkg::ID_SIX_VALUE;
        terf_pkg::ADDR_STATUS:     rd_data_d = status_q;
        terf_pkg::ADDR_CNT_TRACED: rd_data_d = cnt_traced_q;
        terf_pkg::ADDR_CNT_SUPPR:  rd_data_d = cnt_suppr_q;
        // Unmapped addresses read as zero
        default:                   rd_data_d = 32'h0000_0000;
      endcase
    end
  end

  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      rd_data_q <= 32'h0000_0000;
    end else begin
      rd_data_q <= rd_data_d;
    end
  end

  //==========================================================
  // Outputs
  //==========================================================
  assign rd_data_o     = rd_data_q;
  assign trace_valid_o = trace_valid_q;
  assign trace_el_o    = trace_el_q;
  assign trace_sec_o   = trace_sec_q;
  assign trace_pc_o    = trace_pc_q;
  assign suppress_o    = suppress_q;

endmodule

// [terf_filter_sva.sv]
`timescale 1ns/100ps
//==========================================================
// Port checks of the trace level filter
//==========================================================
module terf_filter_sva (
  input wire logic        clk_i,
  input wire logic        rst_i,
  input wire logic [7:0]  addr_i,
  input wire logic [31:0] wr_data_i,
  input wire logic        wr_en_i,
  input wire logic        rd_en_i,
  input wire logic [31:0] rd_data_o,
  input wire logic        retire_valid_i,
  input wire logic [1:0]  retire_el_i,
  input wire logic [1:0]  retire_sec_i,
  input wire logic [31:0] retire_pc_i,
  input wire logic        trace_valid_o,
  input wire logic [1:0]  trace_el_o,
  input wire logic [1:0]  trace_sec_o,
  input wire logic [31:0] trace_pc_o,
  input wire logic        suppress_o
);
  logic [31:0] ctl_q; // Shadow of the stored control word
  logic [31:0] ctl_d; // Its next value
  logic [2:0]  rl_eq; // Realm bit equals its Non-secure partner
  // Shadow follows writes, so checks need no view of the inside
  always_comb begin
    ctl_d = ctl_q;
    if (wr_en_i && addr_i == terf_pkg::ADDR_VIEW_CTL) begin
      ctl_d = wr_data_i & terf_pkg::VIEW_CTL_WMASK;
    end
  end
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      ctl_q <= terf_pkg::VIEW_CTL_RESET;
    end else begin
      ctl_q <= ctl_d;
    end
  end
  assign rl_eq = ctl_q[26:24] ~^ ctl_q[22:20];
  //==========================================================
  // Properties
  //==========================================================
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);
  sequence s_ret(logic [1:0] e, logic [1:0] s);
    retire_valid_i && retire_el_i == e && retire_sec_i == s;
  endsequence
  sequence s_el3;
    retire_valid_i && retire_el_i == 2'd3;
  endsequence
  property p_el3_gen; s_el3 ##0 !ctl_q[19] |=> trace_valid_o && !suppress_o; endproperty
  property p_el3_sup; s_el3 ##0 ctl_q[19] |=> suppress_o && !trace_valid_o; endproperty
  property p_rl_el0; s_ret(2'd0, 2'b11) |=> trace_valid_o == $past(rl_eq[0]); endproperty
  property p_rl_el1; s_ret(2'd1, 2'b11) |=> trace_valid_o == $past(rl_eq[1]); endproperty
  property p_rl_el2; s_ret(2'd2, 2'b11) |=> trace_valid_o == $past(rl_eq[2]); endproperty
  property p_one; retire_valid_i |=> trace_valid_o != suppress_o; endproperty
  property p_idle; !retire_valid_i |=> !trace_valid_o && !suppress_o; endproperty
  property p_copy;
    retire_valid_i ##1 trace_valid_o |-> trace_pc_o == $past(retire_pc_i)
      && trace_el_o == $past(retire_el_i) && trace_sec_o == $past(retire_sec_i);
  endproperty
  property p_id; rd_en_i && addr_i == terf_pkg::ADDR_ID_SIX |=> rd_data_o[2:0] == 3'b111; endproperty
  a_el3_gen: assert property (p_el3_gen) else $error("EL3 not traced");
  a_el3_sup: assert property (p_el3_sup) else $error("EL3 not suppressed");
  a_rl_el0: assert property (p_rl_el0) else $error("Realm EL0 decision wrong");
  a_rl_el1: assert property (p_rl_el1) else $error("Realm EL1 decision wrong");
  a_rl_el2: assert property (p_rl_el2) else $error("Realm EL2 decision wrong");
  a_one: assert property (p_one) else $error("Retire without one verdict");
  a_idle: assert property (p_idle) else $error("Verdict without retire");
  a_copy: assert property (p_copy) else $error("Traced fields wrong");
  a_id: assert property (p_id) else $error("Realm levels not reported");
endmodule

bind terf_filter terf_filter_sva u_sva (
  .clk_i(clk_i), .rst_i(rst_i), .addr_i(addr_i), .wr_data_i(wr_data_i), .wr_en_i(wr_en_i),
  .rd_en_i(rd_en_i), .rd_data_o(rd_data_o), .retire_valid_i(retire_valid_i), .retire_el_i(retire_el_i),
  .retire_sec_i(retire_sec_i), .retire_pc_i(retire_pc_i), .trace_valid_o(trace_valid_o),
  .trace_el_o(trace_el_o), .trace_sec_o(trace_sec_o), .trace_pc_o(trace_pc_o), .suppress_o(suppress_o)
);

// [terf_core_model.sv]
`timescale 1ns/100ps
//==========================================================
// Core side: reports each retired instruction
//==========================================================
module terf_core_model (
  output logic        retire_valid_o, // Retire pulse
  output logic [1:0]  retire_el_o,    // Level at execution
  output logic [1:0]  retire_sec_o,   // {NSE, NS} at execution
  output logic [31:0] retire_pc_o     // Instruction address
);
  initial begin
    retire_valid_o = 1'b0;
    retire_el_o = 2'h0;
    retire_sec_o = 2'h0;
    retire_pc_o = 32'h0000_0000;
  end
  // One retire with the state it ran in; call just after an edge
  task automatic put(input logic [1:0] e, input logic [1:0] s, input logic [31:0] pc);
    retire_valid_o <= 1'b1;
    retire_el_o <= e;
    retire_sec_o <= s;
    retire_pc_o <= pc;
  endtask
  // Idle fields turn over so a stale copy can never look right
  task automatic stop();
    retire_valid_o <= 1'b0;
    retire_el_o <= ~retire_el_o;
    retire_sec_o <= ~retire_sec_o;
    retire_pc_o <= ~retire_pc_o;
  endtask
endmodule

// [trace_el_realm_filter_test.sv]
`timescale 1ns/100ps
module trace_el_realm_filter_test;
  typedef struct packed {
    logic [31:0] ctl; // Control word
    logic [1:0]  el;  // Retire level
    logic [1:0]  sec; // Retire state
    logic        gen; // Trace expected
  } terf_row_t;
  localparam logic [7:0] CTL = terf_pkg::ADDR_VIEW_CTL;
  localparam logic [7:0] IDS = terf_pkg::ADDR_ID_SIX;
  logic        clk_i = 1'b0;
  logic        rst_i = 1'b1;
  logic [7:0]  addr_i = 8'h00;
  logic [31:0] wr_data_i = 32'h0000_0000;
  logic        wr_en_i = 1'b0;
  logic        rd_en_i = 1'b0;
  logic [31:0] rd_data_o, retire_pc_i, trace_pc_o, rd_v;
  logic [1:0]  retire_el_i, retire_sec_i, trace_el_o, trace_sec_o;
  logic        retire_valid_i, trace_valid_o, suppress_o;
  int          failures = 0;
  int          samples_checked = 0;
  // Equal Realm and Non-secure bits trace, unequal ones suppress;
  // Non-secure and Secure rows keep the other decode arms honest
  terf_row_t   rows [17] = '{
    '{32'h0000_0000, 2'h3, 2'h2, 1'b1}, '{32'h0008_0000, 2'h3, 2'h2, 1'b0},
    '{32'h0008_0000, 2'h3, 2'h0, 1'b0}, '{32'h0000_0000, 2'h0, 2'h3, 1'b1},
    '{32'h0100_0000, 2'h0, 2'h3, 1'b0}, '{32'h0010_0000, 2'h0, 2'h3, 1'b0},
    '{32'h0110_0000, 2'h0, 2'h3, 1'b1}, '{32'h0200_0000, 2'h1, 2'h3, 1'b0},
    '{32'h0220_0000, 2'h1, 2'h3, 1'b1}, '{32'h0040_0000, 2'h2, 2'h3, 1'b0},
    '{32'h0440_0000, 2'h2, 2'h3, 1'b1}, '{32'h0400_0000, 2'h2, 2'h3, 1'b0},
    '{32'h0300_0000, 2'h2, 2'h3, 1'b1}, '{32'h0010_0000, 2'h0, 2'h1, 1'b0},
    '{32'h0070_0000, 2'h1, 2'h0, 1'b1}, '{32'h0008_0000, 2'h3, 2'h3, 1'b0},
    '{32'h0030_0000, 2'h2, 2'h1, 1'b1}};
  always #2 clk_i = ~clk_i;
  terf_filter dut (
    .clk_i(clk_i), .rst_i(rst_i), .addr_i(addr_i), .wr_data_i(wr_data_i), .wr_en_i(wr_en_i),
    .rd_en_i(rd_en_i), .rd_data_o(rd_data_o), .retire_valid_i(retire_valid_i), .retire_el_i(retire_el_i),
    .retire_sec_i(retire_sec_i), .retire_pc_i(retire_pc_i), .trace_valid_o(trace_valid_o),
    .trace_el_o(trace_el_o), .trace_sec_o(trace_sec_o), .trace_pc_o(trace_pc_o), .suppress_o(suppress_o));
  terf_core_model core (.retire_valid_o(retire_valid_i), .retire_el_o(retire_el_i),
    .retire_sec_o(retire_sec_i), .retire_pc_o(retire_pc_i));
  task automatic end_of_test();
    if (failures == 0 && samples_checked > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      failures++;
      $display("MISMATCH t=%0t seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge clk_i);
    addr_i <= a;
    wr_data_i <= d;
    wr_en_i <= 1'b1;
    @(posedge clk_i);
    wr_en_i <= 1'b0;
  endtask
  // Read data stand only in the cycle after the strobe
  task automatic rd(input logic [7:0] a);
    @(posedge clk_i);
    addr_i <= a;
    rd_en_i <= 1'b1;
    @(posedge clk_i);
    rd_en_i <= 1'b0;
    #1;
    rd_v = rd_data_o;
  endtask
  task automatic ret(input logic [1:0] e, input logic [1:0] s, input logic [31:0] pc, input logic g);
    @(posedge clk_i);
    core.put(e, s, pc);
    @(posedge clk_i);
    core.stop();
    #1;
    check(trace_valid_o, g);
    check(suppress_o, !g);
    if (g) begin
      check(trace_pc_o, pc);
      check({trace_el_o, trace_sec_o}, {e, s});
    end
  endtask
  // Watchdog: a hang ends the run as a failure
  initial begin
    repeat (2000) @(posedge clk_i);
    failures++;
    end_of_test();
  end
  initial begin
    repeat (2) @(posedge clk_i);
    rst_i <= 1'b0;
    rd(CTL);
    check(rd_v, 32'h0000_0000);
    wr(IDS, 32'hFFFF_FFFF);
    rd(IDS);
    check(rd_v, 32'h0000_0007);
    wr(CTL, 32'hFFFF_FFFF);
    rd(CTL);
    check(rd_v, 32'h0778_0000);
    rd(8'h40);
    check(rd_v, 32'h0000_0000);
    foreach (rows[i]) begin
      wr(CTL, rows[i].ctl);
      ret(rows[i].el, rows[i].sec, 32'hC0DE_0000 + i, rows[i].gen);
    end
    // Write and retire in one cycle: the retire sees the old word
    wr(CTL, 32'h0008_0000);
    @(posedge clk_i);
    wr_data_i <= 32'h0000_0000;
    wr_en_i <= 1'b1;
    core.put(2'h3, 2'h2, 32'hA000_0000);
    @(posedge clk_i);
    wr_en_i <= 1'b0;
    core.put(2'h3, 2'h2, 32'hA000_0004);
    #1;
    check(suppress_o, 1'b1);
    @(posedge clk_i);
    core.stop();
    #1;
    check(trace_pc_o, 32'hA000_0004);
    // Ten retires were filtered out since the first reset
    rd(terf_pkg::ADDR_CNT_SUPPR);
    check(rd_v, 32'h0000_000A);
    // Reset in mid-run clears the word again
    wr(CTL, 32'h0100_0000);
    @(posedge clk_i);
    rst_i <= 1'b1;
    @(posedge clk_i);
    rst_i <= 1'b0;
    rd(CTL);
    check(rd_v, 32'h0000_0000);
    rd(terf_pkg::ADDR_CNT_SUPPR);
    check(rd_v, 32'h0000_0000);
    ret(2'h0, 2'h3, 32'hB000_0000, 1'b1);
    rd(terf_pkg::ADDR_CNT_TRACED);
    check(rd_v, 32'h0000_0001);
    // Status: traced, seen, level 0, Realm state
    rd(terf_pkg::ADDR_STATUS);
    check(rd_v, 32'h0000_0033);
    // Clear and traced retire in one cycle: the count restarts at one
    @(posedge clk_i);
    addr_i <= terf_pkg::ADDR_CNT_TRACED;
    wr_en_i <= 1'b1;
    core.put(2'h0, 2'h1, 32'hB000_0004);
    @(posedge clk_i);
    wr_en_i <= 1'b0;
    core.stop();
    #1;
    check(trace_valid_o, 1'b1);
    rd(terf_pkg::ADDR_CNT_TRACED);
    check(rd_v, 32'h0000_0001);
    end_of_test();
  end
endmodule
